// File: src/sgcb_top.v
// Functional notes
// - length check off: accept frames up to and including 1536 bytes.
// - length check on: drop tagged over 1522, untagged over 1518 bytes.
// - bit 7 enables 802.1Q VLAN; software fills VLAN table first.
// - IGMP snoop bit forwards every IGMP frame to the host MII port.
// - fair queuing off: per-port priority bit selects scheduling method.
// - fair queuing with all queues busy shares bandwidth 8:4:2:1.
// - unless all queues are busy, highest busy queue gets one extra weight; empty queues get zero.
// - sniff select one needs both ports matching, zero needs either.
// - host MII port half duplex when bit 6 set, else full.
// - bit 5 enables host MII pause flow control; resets to one.
// - host MII port runs 10 Mbps when bit 4 set, else 100.
// - null VLAN ID replaced by ingress port default VID when enabled.
// - reserved bits of all three registers read zero.
// - huge frame bit accepts up to 1916 bytes, overriding the check.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "sgcb_defs.vh"

module sgcb_top (
  input  wire                    clk_in,
  input  wire                    rst_n_in,
  input  wire                    ce_in,
  // register port
  input  wire [`SGCB_ADDR_W-1:0] reg_addr_in,
  input  wire [7:0]              reg_wdata_in,
  input  wire                    reg_wr_in,
  input  wire                    reg_rd_in,
  output reg  [7:0]              reg_rdata_out,
  // ingress frame descriptor
  input  wire                    frm_valid_in,
  input  wire [`SGCB_LEN_W-1:0]  frm_len_in,
  input  wire                    frm_tagged_in,
  input  wire                    frm_igmp_in,
  input  wire                    frm_src_match_in,
  input  wire                    frm_dst_match_in,
  input  wire [11:0]             frm_vid_in,
  input  wire [11:0]             port_default_vid_in,
  output reg                     frm_done_out,
  output reg                     frm_drop_out,
  output reg                     frm_mirror_out,
  output reg                     frm_to_host_out,
  output reg  [11:0]             frm_vid_out,
  // egress scheduler
  input  wire [2:0]              port_strict_in,
  input  wire [1:0]              port_sel_in,
  input  wire [3:0]              q_busy_in,
  input  wire                    slot_in,
  output reg  [1:0]              grant_q_out,
  output reg                     grant_vld_out,
  // settings to the datapath
  output reg                     vlan_en_out,
  output reg                     igmp_snoop_out,
  output reg                     host_half_dup_out,
  output reg                     host_flow_en_out,
  output reg                     host_speed_10_out
);

  reg  [7:0] frame_len_reg;
  reg  [7:0] vlan_queue_reg;
  reg  [7:0] host_port_reg;
  reg  [7:0] rd_next;

  wire       chk_done;
  wire       chk_drop;
  wire       chk_mirror;
  wire [1:0] sch_q;
  wire       sch_vld;

  // writes keep only implemented bits; reserved ones stay zero
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_len_reg  <= `SGCB_RST_FRAME_LEN;
      vlan_queue_reg <= `SGCB_RST_VLAN_QUEUE;
      host_port_reg  <= `SGCB_RST_HOST_PORT;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        // bit 0 is masked: a stray one from software cannot stick
        `SGCB_OFF_FRAME_LEN:  frame_len_reg  <= reg_wdata_in & `SGCB_MASK_FRAME_LEN;
        `SGCB_OFF_VLAN_QUEUE: vlan_queue_reg <= reg_wdata_in & `SGCB_MASK_VLAN_QUEUE;
        `SGCB_OFF_HOST_PORT:  host_port_reg  <= reg_wdata_in & `SGCB_MASK_HOST_PORT;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr_in)
      `SGCB_OFF_FRAME_LEN:  rd_next = frame_len_reg;
      `SGCB_OFF_VLAN_QUEUE: rd_next = vlan_queue_reg;
      `SGCB_OFF_HOST_PORT:  rd_next = host_port_reg;
      default:              rd_next = 8'h00;
    endcase
  end

  // read data held only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rd_next : 8'h00;
    end
  end

  // settings registered out; they follow the control bits live
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      vlan_en_out       <= 1'b0;
      igmp_snoop_out    <= 1'b0;
      host_half_dup_out <= 1'b0;
      host_flow_en_out  <= 1'b0;
      host_speed_10_out <= 1'b0;
    end else if (ce_in) begin
      vlan_en_out       <= vlan_queue_reg[`SGCB_BIT_VLAN_EN];
      igmp_snoop_out    <= vlan_queue_reg[`SGCB_BIT_IGMP_EN];
      host_half_dup_out <= host_port_reg[`SGCB_BIT_HALF_DUP];
      host_flow_en_out  <= host_port_reg[`SGCB_BIT_FLOW_EN];
      host_speed_10_out <= host_port_reg[`SGCB_BIT_SPEED_10];
    end
  end

  // length verdict and mirroring; settings sampled per frame
  sgcb_frame_check u_chk (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .ce_in            (ce_in),
    .huge_en_in       (frame_len_reg[`SGCB_BIT_HUGE]),
    .legal_chk_in     (frame_len_reg[`SGCB_BIT_LEGAL_CHK]),
    .sniff_and_in     (vlan_queue_reg[`SGCB_BIT_SNIFF_AND]),
    .frm_valid_in     (frm_valid_in),
    .frm_len_in       (frm_len_in),
    .frm_tagged_in    (frm_tagged_in),
    .frm_src_match_in (frm_src_match_in),
    .frm_dst_match_in (frm_dst_match_in),
    .frm_done_out     (chk_done),
    .frm_drop_out     (chk_drop),
    .frm_mirror_out   (chk_mirror)
  );

  sgcb_wfq_sched u_sch (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .ce_in          (ce_in),
    .wfq_en_in      (vlan_queue_reg[`SGCB_BIT_WFQ_EN]),
    .port_strict_in (port_strict_in),
    .port_sel_in    (port_sel_in),
    .q_busy_in      (q_busy_in),
    .slot_in        (slot_in),
    .grant_q_out    (sch_q),
    .grant_vld_out  (sch_vld)
  );

  // igmp forward and vid replacement, one cycle ahead of the length verdict
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      frm_to_host_out <= 1'b0;
      frm_vid_out     <= 12'h000;
    end else if (ce_in) begin
      frm_to_host_out <= frm_valid_in & frm_igmp_in &
                         vlan_queue_reg[`SGCB_BIT_IGMP_EN];
      if (frm_valid_in) begin
        frm_vid_out <= (host_port_reg[`SGCB_BIT_NULL_VID] && (frm_vid_in == 12'h000)) ?
                       port_default_vid_in : frm_vid_in;
      end
    end
  end

  // one more stage so every output leaves from a top-level flop
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      frm_done_out   <= 1'b0;
      frm_drop_out   <= 1'b0;
      frm_mirror_out <= 1'b0;
      grant_q_out    <= 2'h0;
      grant_vld_out  <= 1'b0;
    end else if (ce_in) begin
      frm_done_out   <= chk_done;
      frm_drop_out   <= chk_drop;
      frm_mirror_out <= chk_mirror;
      grant_q_out    <= sch_q;
      grant_vld_out  <= sch_vld;
    end
  end

endmodule

// File: src/sgcb_defs.vh
`ifndef SGCB_DEFS_VH
`define SGCB_DEFS_VH

// register offsets (byte addresses on the plain register port)
`define SGCB_ADDR_W            8
`define SGCB_OFF_FRAME_LEN     8'h04
`define SGCB_OFF_VLAN_QUEUE    8'h05
`define SGCB_OFF_HOST_PORT     8'h06

// frame length register fields
`define SGCB_BIT_HUGE          2
`define SGCB_BIT_LEGAL_CHK     1
`define SGCB_BIT_LEN_RSVD      0
`define SGCB_RST_FRAME_LEN     8'h00
`define SGCB_MASK_FRAME_LEN    8'hFE

// vlan / queue register fields
`define SGCB_BIT_VLAN_EN       7
`define SGCB_BIT_IGMP_EN       6
`define SGCB_BIT_WFQ_EN        3
`define SGCB_BIT_SNIFF_AND     0
`define SGCB_RST_VLAN_QUEUE    8'h00
`define SGCB_MASK_VLAN_QUEUE   8'hC9

// host port register fields
`define SGCB_BIT_HALF_DUP      6
`define SGCB_BIT_FLOW_EN       5
`define SGCB_BIT_SPEED_10      4
`define SGCB_BIT_NULL_VID      3
`define SGCB_RST_HOST_PORT     8'h20
`define SGCB_MASK_HOST_PORT    8'h78

// frame length limits in bytes
`define SGCB_LEN_W             11
`define SGCB_LEN_ANY_MAX       11'h600
`define SGCB_LEN_TAG_MAX       11'h5F2
`define SGCB_LEN_UNTAG_MAX     11'h5EE
`define SGCB_LEN_HUGE_MAX      11'h77C

// weighted fair queue weights q3..q0
`define SGCB_WGT_W             4
`define SGCB_WGT_Q3            4'h8
`define SGCB_WGT_Q2            4'h4
`define SGCB_WGT_Q1            4'h2
`define SGCB_WGT_Q0            4'h1

`endif

// File: src/sgcb_frame_check.v
`timescale 1ns/1ps
`include "sgcb_defs.vh"

// registered per-frame length verdict and mirror decision
module sgcb_frame_check (
  input  wire                   clk_in,
  input  wire                   rst_n_in,
  input  wire                   ce_in,
  input  wire                   huge_en_in,
  input  wire                   legal_chk_in,
  input  wire                   sniff_and_in,
  input  wire                   frm_valid_in,
  input  wire [`SGCB_LEN_W-1:0] frm_len_in,
  input  wire                   frm_tagged_in,
  input  wire                   frm_src_match_in,
  input  wire                   frm_dst_match_in,
  output reg                    frm_done_out,
  output reg                    frm_drop_out,
  output reg                    frm_mirror_out
);

  reg [`SGCB_LEN_W-1:0] limit;

  // huge frames override the legal check
  always @* begin
    if (huge_en_in) begin
      limit = `SGCB_LEN_HUGE_MAX;
    end else if (legal_chk_in) begin
      limit = frm_tagged_in ? `SGCB_LEN_TAG_MAX : `SGCB_LEN_UNTAG_MAX;
    end else begin
      limit = `SGCB_LEN_ANY_MAX;
    end
  end

  // verdict lands one cycle after the frame descriptor
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      frm_done_out   <= 1'b0;
      frm_drop_out   <= 1'b0;
      frm_mirror_out <= 1'b0;
    end else if (ce_in) begin
      frm_done_out   <= frm_valid_in;
      frm_drop_out   <= frm_valid_in & (frm_len_in > limit);
      frm_mirror_out <= frm_valid_in & (sniff_and_in ?
                        (frm_src_match_in & frm_dst_match_in) :
                        (frm_src_match_in | frm_dst_match_in));
    end
  end

endmodule

// File: src/sgcb_wfq_sched.v
`timescale 1ns/1ps
`include "sgcb_defs.vh"

// egress queue picker: weighted fair, strict priority or round robin
module sgcb_wfq_sched (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       ce_in,
  input  wire       wfq_en_in,
  input  wire [2:0] port_strict_in,
  input  wire [1:0] port_sel_in,
  input  wire [3:0] q_busy_in,
  input  wire       slot_in,
  output reg  [1:0] grant_q_out,
  output reg        grant_vld_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg [1:0]             state_reg;
  reg [1:0]             cur_q_reg;
  reg [`SGCB_WGT_W-1:0] credit_reg;
  reg [1:0]             top_q;
  reg [1:0]             next_q;
  reg                   strict;

  // base weight, plus one for the highest non-empty queue unless all four are busy
  function [`SGCB_WGT_W-1:0] weight;
    input [1:0] q;
    input [3:0] busy;
    input [1:0] top;
    reg   [`SGCB_WGT_W-1:0] base;
    begin
      case (q)
        2'h3:    base = `SGCB_WGT_Q3;
        2'h2:    base = `SGCB_WGT_Q2;
        2'h1:    base = `SGCB_WGT_Q1;
        default: base = `SGCB_WGT_Q0;
      endcase
      if (!busy[q]) begin
        weight = 4'h0;
      end else if ((busy != 4'hF) && (q == top)) begin
        weight = base + 4'h1;
      end else begin
        weight = base;
      end
    end
  endfunction

  // highest busy queue and next busy queue below the current one
  always @* begin
    top_q  = q_busy_in[3] ? 2'h3 : q_busy_in[2] ? 2'h2 : q_busy_in[1] ? 2'h1 : 2'h0;
    next_q = cur_q_reg - 2'h1;
    if (!q_busy_in[next_q]) next_q = next_q - 2'h1;
    if (!q_busy_in[next_q]) next_q = next_q - 2'h1;
    if (!q_busy_in[next_q]) next_q = next_q - 2'h1;
    // strict priority per port when fair queuing is off
    strict = (port_sel_in < 2'h3) ? port_strict_in[port_sel_in] : 1'b0;
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg     <= ST_IDLE;
      cur_q_reg     <= 2'h0;
      credit_reg    <= 4'h0;
      grant_q_out   <= 2'h0;
      grant_vld_out <= 1'b0;
    end else if (ce_in) begin
      grant_vld_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (slot_in && (q_busy_in != 4'h0)) begin
            if (wfq_en_in) begin
              cur_q_reg     <= top_q;
              credit_reg    <= weight(top_q, q_busy_in, top_q) - 4'h1;
              grant_q_out   <= top_q;
              grant_vld_out <= 1'b1;
              state_reg     <= ST_RUN;
            end else begin
              // non-strict ports get plain round robin across busy queues
              grant_q_out   <= strict ? top_q : next_q;
              cur_q_reg     <= strict ? top_q : next_q;
              grant_vld_out <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (!wfq_en_in || (q_busy_in == 4'h0)) begin
            state_reg <= ST_IDLE; // fair mode left on the fly
          end else if (slot_in) begin
            grant_vld_out <= 1'b1;
            if ((credit_reg != 4'h0) && q_busy_in[cur_q_reg]) begin
              credit_reg  <= credit_reg - 4'h1;
              grant_q_out <= cur_q_reg;
            end else begin
              cur_q_reg   <= next_q;
              credit_reg  <= weight(next_q, q_busy_in, top_q) - 4'h1;
              grant_q_out <= next_q;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: tb/sgcb_top_asserts.sv
`timescale 1ns/1ps
// watches read-back, frame verdicts and grants at the top ports
module sgcb_top_asserts (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        ce_in,
  input wire [7:0]  reg_addr_in,
  input wire        reg_rd_in,
  input wire [7:0]  reg_rdata_out,
  input wire        frm_valid_in,
  input wire [10:0] frm_len_in,
  input wire        frm_igmp_in,
  input wire        frm_src_match_in,
  input wire        frm_dst_match_in,
  input wire [11:0] frm_vid_in,
  input wire        frm_done_out,
  input wire        frm_drop_out,
  input wire        frm_mirror_out,
  input wire        frm_to_host_out,
  input wire [11:0] frm_vid_out,
  input wire [3:0]  q_busy_in,
  input wire        slot_in,
  input wire [1:0]  grant_q_out,
  input wire        grant_vld_out
);
  logic [3:0] busy_d1;
  logic [3:0] busy_d2;
  // busy flags as they stood when the granting slot was taken
  always @(posedge clk_in) begin
    busy_d1 <= q_busy_in;
    busy_d2 <= busy_d1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_frame; frm_valid_in && ce_in; endsequence
  sequence s_slot; slot_in && ce_in && (q_busy_in != 4'h0); endsequence
  sequence s_rd(a); reg_rd_in && ce_in && (reg_addr_in == a); endsequence

  chk_rsvd_vlan: assert property (s_rd(8'h05) |=> (reg_rdata_out & 8'h36) == 8'h00)
    else $error("reserved vlan queue bits read nonzero");
  chk_rsvd_host: assert property (s_rd(8'h06) |=> (reg_rdata_out & 8'h87) == 8'h00)
    else $error("reserved host port bits read nonzero");
  chk_rsvd_len: assert property (s_rd(8'h04) |=> !reg_rdata_out[0])
    else $error("reserved length bit read nonzero");
  chk_huge_drop: assert property (s_frame ##0 (frm_len_in > 11'h77C) |-> ##2 frm_done_out && frm_drop_out)
    else $error("frame above huge limit not dropped");
  chk_short_pass: assert property (s_frame ##0 (frm_len_in <= 11'h5EE) |-> ##2 frm_done_out && !frm_drop_out)
    else $error("short frame dropped or late");
  chk_mirror_both: assert property (s_frame ##0 (frm_src_match_in && frm_dst_match_in) |-> ##2 frm_mirror_out)
    else $error("frame matching both ports not mirrored");
  chk_mirror_none: assert property (s_frame ##0 (!frm_src_match_in && !frm_dst_match_in) |-> ##2 !frm_mirror_out)
    else $error("frame matching no port mirrored");
  chk_host_igmp: assert property (frm_to_host_out |-> $past(frm_valid_in) && $past(frm_igmp_in))
    else $error("non igmp frame sent to host port");
  chk_vid_keep: assert property (s_frame ##0 (frm_vid_in != 12'h000) |=> frm_vid_out == $past(frm_vid_in))
    else $error("non null vid altered");
  chk_grant_lat: assert property (s_slot |-> ##2 grant_vld_out)
    else $error("slot with busy queue not granted");
  chk_grant_busy: assert property (grant_vld_out |-> busy_d2[grant_q_out])
    else $error("grant given to empty queue");
endmodule

// File: tb/tb_sgcb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  num_checks++; \
  if ((a) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, a); fail_count++; end \
end

module tb_sgcb_top;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, slot_in = 1'b0;
  logic        frm_valid_in = 1'b0, frm_tagged_in = 1'b0, frm_igmp_in = 1'b0;
  logic        frm_src_match_in = 1'b0, frm_dst_match_in = 1'b0;
  logic [10:0] frm_len_in = 11'h000;
  logic [11:0] frm_vid_in = 12'h000, port_default_vid_in = 12'h000;
  logic [2:0]  port_strict_in = 3'h1;
  logic [1:0]  port_sel_in = 2'h0;
  logic [3:0]  q_busy_in = 4'h0;
  wire  [7:0]  reg_rdata_out;
  wire  [11:0] frm_vid_out;
  wire  [1:0]  grant_q_out;
  wire         frm_done_out, frm_drop_out, frm_mirror_out, frm_to_host_out, grant_vld_out;
  wire         vlan_en_out, igmp_snoop_out, host_half_dup_out, host_flow_en_out;
  wire         host_speed_10_out;
  int          fail_count = 0, num_checks = 0, seed = 63897;
  logic [7:0]  rq[$];
  logic [1:0]  dq[$];
  logic [12:0] hq[$];
  logic [1:0]  gq[$];
  logic [7:0]  e8;
  logic [12:0] e13;
  logic [1:0]  e2, e3, lq;
  logic        rd_d = 1'b0, v1 = 1'b0, huge, chk, sniff, snoop, nul;
  logic [7:0]  adr[4] = '{8'h04, 8'h05, 8'h06, 8'h3F};
  logic [7:0]  rstv[4] = '{8'h00, 8'h00, 8'h20, 8'h00};
  logic [7:0]  msk[4] = '{8'hFE, 8'hC9, 8'h78, 8'h00};
  logic [10:0] lens[8] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h600, 11'h601, 11'h77C, 11'h77D};

  sgcb_top i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frm_valid_in(frm_valid_in), .frm_len_in(frm_len_in),
    .frm_tagged_in(frm_tagged_in), .frm_igmp_in(frm_igmp_in),
    .frm_src_match_in(frm_src_match_in), .frm_dst_match_in(frm_dst_match_in),
    .frm_vid_in(frm_vid_in), .port_default_vid_in(port_default_vid_in),
    .frm_done_out(frm_done_out), .frm_drop_out(frm_drop_out), .frm_mirror_out(frm_mirror_out),
    .frm_to_host_out(frm_to_host_out), .frm_vid_out(frm_vid_out),
    .port_strict_in(port_strict_in), .port_sel_in(port_sel_in), .q_busy_in(q_busy_in),
    .slot_in(slot_in), .grant_q_out(grant_q_out), .grant_vld_out(grant_vld_out),
    .vlan_en_out(vlan_en_out), .igmp_snoop_out(igmp_snoop_out),
    .host_half_dup_out(host_half_dup_out), .host_flow_en_out(host_flow_en_out),
    .host_speed_10_out(host_speed_10_out)
  );

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one register cycle; strobes all low makes an idle cycle
  task bus(input logic w, r, input logic [7:0] a, d, e);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (r) rq.push_back(e);
    @(posedge clk_in);
  endtask

  // one frame descriptor with random qualifiers, half of them null vid
  task frm(input logic [10:0] len, input logic tg);
    logic [31:0] r;
    logic [11:0] v;
    r = $random(seed);
    v = r[3] ? r[15:4] : 12'h000;
    frm_valid_in <= 1'b1;
    frm_len_in <= len;
    frm_tagged_in <= tg;
    frm_src_match_in <= r[0];
    frm_dst_match_in <= r[1];
    frm_igmp_in <= r[2];
    frm_vid_in <= v;
    port_default_vid_in <= r[27:16];
    dq.push_back({huge ? len > 11'h77C : chk ? len > (tg ? 11'h5F2 : 11'h5EE) : len > 11'h600,
                  sniff ? r[0] & r[1] : r[0] | r[1]});
    hq.push_back({snoop & r[2], (nul && v == 12'h000) ? r[27:16] : v});
    @(posedge clk_in);
  endtask

  // bounded wait until every noted result has been seen
  task drain;
    int k;
    for (k = 0; k < 40 && rq.size() + dq.size() + hq.size() + gq.size() > 0; k++) @(posedge clk_in);
    if (k == 40) begin
      fail_count++;
      test_done();
    end
  endtask

  // result watcher: takes the oldest note when a result shows
  always @(posedge clk_in) begin
    rd_d <= reg_rd_in;
    v1 <= frm_valid_in;
    if (rd_d) begin
      e8 = rq.pop_front();
      `CHK("rdata", e8, reg_rdata_out)
    end
    if (v1) begin
      e13 = hq.pop_front();
      `CHK("to_host", e13[12], frm_to_host_out)
      `CHK("vid", e13[11:0], frm_vid_out)
    end
    if (frm_done_out) begin
      e2 = dq.pop_front();
      `CHK("drop", e2[1], frm_drop_out)
      `CHK("mirror", e2[0], frm_mirror_out)
    end
    if (grant_vld_out) begin
      e3 = gq.pop_front();
      `CHK("grant", e3, grant_q_out)
    end
  end

  initial begin
    int i, k, m;
    logic [31:0] r;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    for (i = 0; i < 4; i++) bus(1'b0, 1'b1, adr[i], 8'h00, rstv[i]);
    `CHK("settings", 5'b00010, {vlan_en_out, igmp_snoop_out, host_half_dup_out,
                                host_flow_en_out, host_speed_10_out})
    // random write then read back, reserved length bit kept clear
    for (i = 0; i < 12; i++) begin
      r = $random(seed) & 32'hFE;
      bus(1'b1, 1'b0, adr[i % 4], r[7:0], 8'h00);
      bus(1'b0, 1'b1, adr[i % 4], 8'h00, r[7:0] & msk[i % 4]);
    end
    // settings all flipped from reset values, then restored without reset
    for (i = 1; i >= 0; i--) begin
      bus(1'b1, 1'b0, 8'h05, i ? 8'hC0 : 8'h00, 8'h00);
      bus(1'b1, 1'b0, 8'h06, i ? 8'h58 : 8'h20, 8'h00);
      repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      `CHK("settings", i ? 5'b11101 : 5'b00010, {vlan_en_out, igmp_snoop_out, host_half_dup_out,
                        host_flow_en_out, host_speed_10_out})
    end
    // clock enable low: a write in that cycle must not land
    ce_in <= 1'b0;
    bus(1'b1, 1'b0, 8'h06, 8'h58, 8'h00);
    ce_in <= 1'b1;
    bus(1'b0, 1'b1, 8'h06, 8'h00, 8'h20);
    // every length mode with boundary lengths, reconfigured on the fly
    for (m = 0; m < 4; m++) begin
      chk = m[0];
      huge = m[1];
      sniff = m[0];
      snoop = m[1];
      nul = m[1] ^ m[0];
      bus(1'b1, 1'b0, 8'h04, {5'h00, huge, chk, 1'b0}, 8'h00);
      bus(1'b1, 1'b0, 8'h05, {1'b0, snoop, 5'h00, sniff}, 8'h00);
      bus(1'b1, 1'b0, 8'h06, {4'h2, nul, 3'h0}, 8'h00);
      repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      for (k = 0; k < 16; k++) frm(lens[k >> 1], k[0]);
      frm_valid_in <= 1'b0;
      drain();
    end
    // fair queuing: all busy, then q2 empty, slots back to back
    bus(1'b1, 1'b0, 8'h05, 8'h08, 8'h00);
    repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    for (k = 0; k < 27; k++) begin
      slot_in <= 1'b1;
      q_busy_in <= k < 15 ? 4'hF : 4'hB;
      gq.push_back(k < 8 ? 2'd3 : k < 12 ? 2'd2 : k < 14 ? 2'd1 : k < 15 ? 2'd0 :
                   k < 24 ? 2'd3 : k < 26 ? 2'd1 : 2'd0);
      @(posedge clk_in);
    end
    q_busy_in <= 4'h0;
    drain();
    // fair off: strict port grants highest busy queue
    bus(1'b1, 1'b0, 8'h05, 8'h00, 8'h00);
    repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    for (k = 0; k < 8; k++) begin
      r = $random(seed) | 32'h1;
      q_busy_in <= r[3:0];
      lq = r[3] ? 2'd3 : r[2] ? 2'd2 : r[1] ? 2'd1 : 2'd0;
      gq.push_back(lq);
      @(posedge clk_in);
    end
    // non-strict port: round robin downward over busy queues from the last grant
    port_sel_in <= 2'h3;
    for (k = 0; k < 8; k++) begin
      r = $random(seed) | 32'h1;
      q_busy_in <= r[3:0];
      lq = lq - 2'd1;
      for (i = 0; i < 3 && !r[lq]; i++) lq = lq - 2'd1;
      gq.push_back(lq);
      @(posedge clk_in);
    end
    slot_in <= 1'b0;
    drain();
    test_done();
  end
endmodule

bind sgcb_top sgcb_top_asserts i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .frm_valid_in(frm_valid_in),
  .frm_len_in(frm_len_in), .frm_igmp_in(frm_igmp_in), .frm_src_match_in(frm_src_match_in),
  .frm_dst_match_in(frm_dst_match_in), .frm_vid_in(frm_vid_in), .frm_done_out(frm_done_out),
  .frm_drop_out(frm_drop_out), .frm_mirror_out(frm_mirror_out),
  .frm_to_host_out(frm_to_host_out), .frm_vid_out(frm_vid_out), .q_busy_in(q_busy_in),
  .slot_in(slot_in), .grant_q_out(grant_q_out), .grant_vld_out(grant_vld_out)
);
